// ### design/lmp_access_policy.sv
// Purpose: read and write policy of the level-2 cache per memory type
// Assumes: slave port signals and lookup hit come from logic on CLK
// Notes: one registered decision per request, one cycle after it
// Functional notes
// - strongly ordered: uncached reads, unbuffered writes
// - device: uncached reads, unbuffered writes, master access
// - outer noncacheable handled as strongly ordered
// - nonshared cacheable: hit reads L2, miss linefills
// - write-back allocate hit: buffer, write L2, dirty
// - shared write-back allocate: bypass reads, buffered writes
// - write-through hit: buffer, write L2 and master
// - no-allocate write miss: buffer, master, no allocate
// - write-back no-allocate hit: L2 write, dirty only
// - shared no-allocate types: bypass reads, buffered writes
// - device writes bypass the merging write buffer
// - allocate override allocates nonshared cacheable misses
// - shared override uses the nonshared policy
// - noncacheable transfers never look up or hit
// - strobes mark active lanes in address phase
// - all-high strobes, no unaligned flag: lanes from address and size
// - 16-bit at 0x1005 arrives as 0x1004 size 2
// - protection bits zero mean strongly ordered, shared
`timescale 1ns/10ps
`include "lmp_map.svh"
module lmp_access_policy
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // slave port request
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic [31:0] REQ_ADDR,
  input wire logic [2:0] REQ_SIZE,
  input wire logic REQ_ALLOC,
  input wire logic REQ_CACHEABLE,
  input wire logic REQ_BUFFERABLE,
  input wire logic REQ_SHARED,
  input wire logic [7:0] REQ_STRB,
  input wire logic REQ_UNALIGNED,
  input wire logic LOOKUP_HIT,
  // configuration
  input wire logic WA_OVERRIDE,
  input wire logic SHARED_OVERRIDE,
  // decision
  output logic DEC_VALID,
  output logic DEC_WRITE,
  output lmp_pkg::lmp_memtype_e DEC_MEMTYPE,
  output logic DEC_SHARED,
  output logic DEC_LOOKUP,
  output logic DEC_HIT,
  output logic DEC_L2_READ,
  output logic DEC_LINEFILL,
  output logic DEC_MASTER,
  output logic DEC_BUFFERED,
  output logic DEC_NO_MERGE,
  output logic DEC_DRAIN_L2,
  output logic DEC_DRAIN_DIRTY,
  output logic DEC_DRAIN_MASTER,
  output logic DEC_DRAIN_ALLOC,
  output logic DEC_DRAIN_FETCH,
  output logic [7:0] DEC_LANES,
  output logic DEC_UNALIGNED
);
  import lmp_pkg::*;

  lmp_state_s st_q;
  lmp_state_s st_d;
  lmp_memtype_e mt;
  logic eff_shared;
  logic [7:0] lanes;
  logic lanes_derived;
  logic cacheable;
  logic hit;

  // ----------------------------------------
  // attribute decode
  // ----------------------------------------
  lmp_memtype_decode u_decode
  (
    .alloc(REQ_ALLOC),
    .cacheable(REQ_CACHEABLE),
    .bufferable(REQ_BUFFERABLE),
    .shared_sideband_bit(REQ_SHARED),
    .shared_override(SHARED_OVERRIDE),
    .memtype(mt),
    .eff_shared(eff_shared)
  );

  lmp_lane_gen u_lanes
  (
    .addr_low(REQ_ADDR[`LMP_OFS_MSB:0]),
    .slave_port_size(REQ_SIZE),
    .slave_byte_lane_strobes(REQ_STRB),
    .slave_unaligned_flag(REQ_UNALIGNED),
    .lanes(lanes),
    .derived(lanes_derived)
  );

  // ----------------------------------------
  // policy
  // ----------------------------------------
  // only nonshared normal cacheable types reach the cache
  assign cacheable = !eff_shared &&
    (mt == LMP_MT_WBWA || mt == LMP_MT_WTNWA || mt == LMP_MT_WBNWA);
  assign hit = cacheable && LOOKUP_HIT;

  always_comb
  begin
    st_d = '0;
    st_d.valid = REQ_VALID;
    st_d.write = REQ_WRITE;
    st_d.memtype = mt;
    st_d.shared = eff_shared;
    st_d.lanes = lanes;
    st_d.unaligned = REQ_UNALIGNED;
    if (REQ_VALID)
    begin
      st_d.lookup = cacheable;
      st_d.hit = hit;
      if (!REQ_WRITE)
      begin
        if (cacheable)
        begin
          st_d.l2_read = hit;
          st_d.linefill = !hit;
        end
        else
        begin
          st_d.master = 1'b1;
        end
      end
      else if (mt == LMP_MT_SO || mt == LMP_MT_DEV || mt == LMP_MT_ONC)
      begin
        st_d.master = 1'b1;
        st_d.no_merge = (mt == LMP_MT_DEV);
      end
      else if (!cacheable)
      begin
        st_d.buffered = 1'b1;
        st_d.drain_master = 1'b1;
      end
      else if (hit)
      begin
        st_d.buffered = 1'b1;
        st_d.drain_l2 = 1'b1;
        st_d.drain_dirty = (mt != LMP_MT_WTNWA);
        st_d.drain_master = (mt == LMP_MT_WTNWA);
      end
      else if (mt == LMP_MT_WBWA || WA_OVERRIDE)
      begin
        st_d.buffered = 1'b1;
        st_d.drain_alloc = 1'b1;
        st_d.drain_fetch = (lanes != `LMP_LANES_ALL);
      end
      else
      begin
        st_d.buffered = 1'b1;
        st_d.drain_master = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign DEC_VALID = st_q.valid;
  assign DEC_WRITE = st_q.write;
  assign DEC_MEMTYPE = st_q.memtype;
  assign DEC_SHARED = st_q.shared;
  assign DEC_LOOKUP = st_q.lookup;
  assign DEC_HIT = st_q.hit;
  assign DEC_L2_READ = st_q.l2_read;
  assign DEC_LINEFILL = st_q.linefill;
  assign DEC_MASTER = st_q.master;
  assign DEC_BUFFERED = st_q.buffered;
  assign DEC_NO_MERGE = st_q.no_merge;
  assign DEC_DRAIN_L2 = st_q.drain_l2;
  assign DEC_DRAIN_DIRTY = st_q.drain_dirty;
  assign DEC_DRAIN_MASTER = st_q.drain_master;
  assign DEC_DRAIN_ALLOC = st_q.drain_alloc;
  assign DEC_DRAIN_FETCH = st_q.drain_fetch;
  assign DEC_LANES = st_q.lanes;
  assign DEC_UNALIGNED = st_q.unaligned;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  so_uncached_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && mt == LMP_MT_SO) |=> (DEC_MASTER && !DEC_BUFFERED && !DEC_LOOKUP))
    else $error("strongly ordered transfer not sent straight out");

  dev_no_merge_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_WRITE && mt == LMP_MT_DEV) |=> (DEC_MASTER && DEC_NO_MERGE && !DEC_BUFFERED))
    else $error("device write not unbuffered");

  onc_as_so_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && !REQ_ALLOC && REQ_CACHEABLE && !REQ_BUFFERABLE)
    |=> (DEC_MASTER && !DEC_LINEFILL && !DEC_BUFFERED && !DEC_NO_MERGE))
    else $error("outer noncacheable not handled as strongly ordered");

  read_hit_miss_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && !REQ_WRITE && cacheable)
    |=> (DEC_L2_READ == $past(LOOKUP_HIT)) && (DEC_LINEFILL != $past(LOOKUP_HIT)) && !DEC_MASTER)
    else $error("cacheable read not served by cache");

  wbwa_hit_dirty_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_WRITE && hit && mt == LMP_MT_WBWA)
    |=> (DEC_BUFFERED && DEC_DRAIN_L2 && DEC_DRAIN_DIRTY && !DEC_DRAIN_MASTER))
    else $error("write-back allocate hit not dirtied");

  alloc_miss_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_WRITE && cacheable && !LOOKUP_HIT && mt == LMP_MT_WBWA)
    |=> (DEC_DRAIN_ALLOC && (DEC_DRAIN_FETCH == (DEC_LANES != `LMP_LANES_ALL))))
    else $error("allocating miss wrong");

  shared_bypass_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_SHARED && !SHARED_OVERRIDE && REQ_CACHEABLE && REQ_BUFFERABLE)
    |=> (!DEC_LOOKUP && (DEC_WRITE ? (DEC_BUFFERED && DEC_DRAIN_MASTER) : DEC_MASTER)))
    else $error("shared write-back allocate not bypassed");

  wt_hit_both_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_WRITE && hit && mt == LMP_MT_WTNWA)
    |=> (DEC_DRAIN_L2 && DEC_DRAIN_MASTER && !DEC_DRAIN_DIRTY))
    else $error("write-through hit not written both ways");

  noalloc_miss_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_WRITE && cacheable && !LOOKUP_HIT && !WA_OVERRIDE && mt != LMP_MT_WBWA)
    |=> (DEC_BUFFERED && DEC_DRAIN_MASTER && !DEC_DRAIN_ALLOC))
    else $error("no-allocate miss allocated");

  wbnwa_hit_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_WRITE && hit && mt == LMP_MT_WBNWA)
    |=> (DEC_DRAIN_DIRTY && !DEC_DRAIN_MASTER))
    else $error("write-back no-allocate hit went out");

  shared_na_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_WRITE && REQ_SHARED && !SHARED_OVERRIDE && REQ_ALLOC && REQ_CACHEABLE)
    |=> (DEC_BUFFERED && DEC_DRAIN_MASTER && !DEC_DRAIN_L2))
    else $error("shared no-allocate write wrong");

  override_alloc_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_WRITE && WA_OVERRIDE && cacheable && !LOOKUP_HIT) |=> DEC_DRAIN_ALLOC)
    else $error("allocate override ignored");

  share_override_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && SHARED_OVERRIDE && REQ_CACHEABLE && REQ_BUFFERABLE) |=> DEC_LOOKUP)
    else $error("shared override not applied");

  no_nc_hit_a: assert property (@(posedge CLK) disable iff (!RST_N)
    DEC_HIT |-> DEC_LOOKUP && !DEC_MASTER)
    else $error("hit on noncacheable transfer");

  so_shared_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && !REQ_ALLOC && !REQ_CACHEABLE && !REQ_BUFFERABLE)
    |=> (DEC_MEMTYPE == LMP_MT_SO && DEC_SHARED))
    else $error("zero protection not strongly ordered");

  lane_derive_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_SIZE == `LMP_SIZE_MAX && REQ_STRB == `LMP_LANES_ALL && !REQ_UNALIGNED)
    |=> DEC_LANES == `LMP_LANES_ALL)
    else $error("derived lanes wrong");

  unalign_pass_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && REQ_ADDR[`LMP_OFS_MSB:0] == 3'(`LMP_EX_ADDR) && REQ_SIZE == `LMP_EX_SIZE &&
     REQ_STRB == `LMP_EX_STRB && REQ_UNALIGNED)
    |=> (DEC_LANES == `LMP_EX_STRB && DEC_UNALIGNED))
    else $error("unaligned strobes altered");

  strb_pass_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && (REQ_STRB != `LMP_LANES_ALL || REQ_UNALIGNED)) |=> (DEC_LANES == $past(REQ_STRB)))
    else $error("byte strobes not passed through");

  read_bypass_a: assert property (@(posedge CLK) disable iff (!RST_N)
    (REQ_VALID && !REQ_WRITE && (eff_shared || mt == LMP_MT_ONC))
    |=> (DEC_MASTER && !DEC_LOOKUP && !DEC_L2_READ && !DEC_LINEFILL))
    else $error("uncached read not sent to master port");

  read_hit_c: cover property (@(posedge CLK) disable iff (!RST_N) DEC_L2_READ);
  linefill_c: cover property (@(posedge CLK) disable iff (!RST_N) DEC_LINEFILL);
  alloc_fetch_c: cover property (@(posedge CLK) disable iff (!RST_N) DEC_DRAIN_FETCH);
  device_write_c: cover property (@(posedge CLK) disable iff (!RST_N) DEC_NO_MERGE);
  bypass_read_c: cover property (@(posedge CLK) disable iff (!RST_N) DEC_MASTER && !DEC_WRITE);

endmodule : lmp_access_policy

// ### design/lmp_map.svh
// Purpose: constants of the memory-type access policy block
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef LMP_MAP_SVH
`define LMP_MAP_SVH

// ----------------------------------------
// slave port encodings
// ----------------------------------------
`define LMP_SIZE_MAX 3'h3
`define LMP_BYTES_MAX 4'h8
`define LMP_LANES_ALL 8'hFF
`define LMP_LANES_NONE 8'h00
`define LMP_OFS_MSB 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define LMP_RST_BIT 1'h0
`define LMP_RST_LANES 8'h00

// ----------------------------------------
// little-endian unaligned example
// ----------------------------------------
`define LMP_EX_ADDR 32'h0000_1004
`define LMP_EX_SIZE 3'h2
`define LMP_EX_STRB 8'h60

`endif

// ### design/lmp_pkg.sv
// Purpose: types of the memory-type access policy block
// Assumes: nothing
// Notes: memory type codes are internal only
package lmp_pkg;

  typedef enum logic [2:0]
  {
    LMP_MT_SO = 3'h0,
    LMP_MT_DEV = 3'h1,
    LMP_MT_WBWA = 3'h2,
    LMP_MT_ONC = 3'h3,
    LMP_MT_WTNWA = 3'h6,
    LMP_MT_WBNWA = 3'h7
  } lmp_memtype_e;

  typedef struct packed
  {
    logic valid;
    logic write;
    lmp_memtype_e memtype;
    logic shared;
    logic lookup;
    logic hit;
    logic l2_read;
    logic linefill;
    logic master;
    logic buffered;
    logic no_merge;
    logic drain_l2;
    logic drain_dirty;
    logic drain_master;
    logic drain_alloc;
    logic drain_fetch;
    logic [7:0] lanes;
    logic unaligned;
  } lmp_state_s;

endpackage : lmp_pkg

// ### design/lmp_memtype_decode.sv
// Purpose: protection and shared bits to memory type and effective sharing
// Assumes: inputs from logic on the same clock
// Notes: purely combinational
`timescale 1ns/10ps
module lmp_memtype_decode
(
  // transfer attributes
  input wire logic alloc,
  input wire logic cacheable,
  input wire logic bufferable,
  input wire logic shared_sideband_bit,
  // configuration
  input wire logic shared_override,
  // decoded
  output lmp_pkg::lmp_memtype_e memtype,
  output logic eff_shared
);
  import lmp_pkg::*;

  always_comb
  begin
    memtype = LMP_MT_SO;
    case ({alloc, cacheable, bufferable})
      3'h0: memtype = LMP_MT_SO;
      3'h1: memtype = LMP_MT_DEV;
      3'h2: memtype = LMP_MT_ONC;
      3'h3: memtype = LMP_MT_WBWA;
      3'h6: memtype = LMP_MT_WTNWA;
      3'h7: memtype = LMP_MT_WBNWA;
      // undefined alloc without cacheable: safest as strongly ordered
      default: memtype = LMP_MT_SO;
    endcase
  end

  // strongly ordered and device are shared whatever the sideband says
  always_comb
  begin
    if (memtype == LMP_MT_SO || memtype == LMP_MT_DEV)
    begin
      eff_shared = 1'b1;
    end
    else
    begin
      eff_shared = shared_sideband_bit && !shared_override;
    end
  end

endmodule : lmp_memtype_decode

// ### design/lmp_lane_gen.sv
// Purpose: internal byte lanes from strobes, or from address and size
// Assumes: address aligned down to the size by the master
// Notes: purely combinational
`timescale 1ns/10ps
`include "lmp_map.svh"
module lmp_lane_gen
(
  // slave port address phase
  input wire logic [2:0] addr_low,
  input wire logic [2:0] slave_port_size,
  input wire logic [7:0] slave_byte_lane_strobes,
  input wire logic slave_unaligned_flag,
  // result
  output logic [7:0] lanes,
  output logic derived
);
  logic [3:0] ofs;
  logic [3:0] nbytes;
  logic [7:0] from_addr;

  assign ofs = {1'b0, addr_low};

  always_comb
  begin
    case (slave_port_size)
      3'h0: nbytes = 4'h1;
      3'h1: nbytes = 4'h2;
      3'h2: nbytes = 4'h4;
      default: nbytes = `LMP_BYTES_MAX;
    endcase
  end

  for (genvar i = 0; i < 8; i++)
  begin : g_lane
    assign from_addr[i] = (4'(i) >= ofs) && ({1'b0, 4'(i)} < ({1'b0, ofs} + {1'b0, nbytes}));
  end

  // all-high strobes with no unaligned flag means a system without strobes
  assign derived = (slave_byte_lane_strobes == `LMP_LANES_ALL) && !slave_unaligned_flag;
  assign lanes = derived ? from_addr : slave_byte_lane_strobes;

endmodule : lmp_lane_gen

// ### dv/lmp_core_model.sv
// Purpose: core side of the slave port, one single transfer per call
// Assumes: called by the bench just after the falling clock edge
// Notes: never issues bursts; idle cycles show inverted address and strobes
`timescale 1ns/10ps
module lmp_core_model
(
  // slave port request
  output logic req_valid,
  output logic req_write,
  output logic [31:0] req_addr,
  output logic [2:0] req_size,
  output logic req_alloc,
  output logic req_cacheable,
  output logic req_bufferable,
  output logic req_shared,
  output logic [7:0] req_strb,
  output logic req_unaligned,
  // tag side
  output logic lookup_hit
);
  // ----------------------------------------
  // address phase of one transfer
  // ----------------------------------------
  task automatic put(input logic v, input logic w, input logic [2:0] acb,
    input logic s, input logic h, input logic [2:0] sz, input logic [31:0] ad,
    input logic [7:0] st, input logic un);
    logic [31:0] mask;
    mask = 32'hFFFF_FFFF << (sz > 3'h3 ? 3'h3 : sz);
    req_valid = v;
    req_write = w;
    {req_alloc, req_cacheable, req_bufferable} = acb;
    req_shared = s;
    lookup_hit = h;
    req_size = sz;
    req_addr = v ? (ad & mask) : ~req_addr;
    req_strb = v ? st : ~req_strb;
    req_unaligned = un;
  endtask : put

  initial
  begin
    req_addr = 32'h0000_0000;
    req_strb = 8'h00;
    put(1'h0, 1'h0, 3'h0, 1'h0, 1'h0, 3'h0, 32'h0, 8'h00, 1'h0);
  end
endmodule : lmp_core_model

// ### dv/l2_memtype_access_policy_tb.sv
// Purpose: self-checking bench of the memory-type access policy
// Assumes: decisions appear one cycle after each request
// Notes: corner cases, then 600 cycles of seeded random traffic with random idle cycles
`timescale 1ns/10ps
`define CHK(g, e) check_val(64'(g), 64'(e))
module l2_memtype_access_policy_tb;
  import lmp_pkg::*;
  logic clk, rst_n, wa_ov, sh_ov;
  logic req_valid, req_write, req_alloc, req_cacheable, req_bufferable, req_shared;
  logic req_unaligned, lookup_hit, dec_valid, dec_write, dec_shared, dec_unaligned;
  logic [31:0] req_addr;
  logic [2:0] req_size, sz, ofs;
  logic [7:0] req_strb, dec_lanes, st;
  logic [11:0] dec_bits, e_bits;
  lmp_memtype_e dec_memtype, e_mt;
  logic e_v, e_w, e_sh, e_un, leg;
  logic [7:0] e_lanes;
  int n_fail, checked, cyc, seed;

  lmp_core_model u_lmp_core_model (.req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_size(req_size), .req_alloc(req_alloc),
    .req_cacheable(req_cacheable), .req_bufferable(req_bufferable),
    .req_shared(req_shared), .req_strb(req_strb), .req_unaligned(req_unaligned),
    .lookup_hit(lookup_hit));

  lmp_access_policy u_lmp_access_policy (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_ADDR(req_addr), .REQ_SIZE(req_size), .REQ_ALLOC(req_alloc),
    .REQ_CACHEABLE(req_cacheable), .REQ_BUFFERABLE(req_bufferable), .REQ_SHARED(req_shared),
    .REQ_STRB(req_strb), .REQ_UNALIGNED(req_unaligned), .LOOKUP_HIT(lookup_hit),
    .WA_OVERRIDE(wa_ov), .SHARED_OVERRIDE(sh_ov), .DEC_VALID(dec_valid),
    .DEC_WRITE(dec_write), .DEC_MEMTYPE(dec_memtype), .DEC_SHARED(dec_shared),
    .DEC_LOOKUP(dec_bits[11]), .DEC_HIT(dec_bits[10]), .DEC_L2_READ(dec_bits[9]),
    .DEC_LINEFILL(dec_bits[8]), .DEC_MASTER(dec_bits[7]), .DEC_BUFFERED(dec_bits[6]),
    .DEC_NO_MERGE(dec_bits[5]), .DEC_DRAIN_L2(dec_bits[4]), .DEC_DRAIN_DIRTY(dec_bits[3]),
    .DEC_DRAIN_MASTER(dec_bits[2]), .DEC_DRAIN_ALLOC(dec_bits[1]),
    .DEC_DRAIN_FETCH(dec_bits[0]), .DEC_LANES(dec_lanes), .DEC_UNALIGNED(dec_unaligned));

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic lmp_memtype_e exp_mt(input logic [2:0] acb);
    if (!acb[1])
      return (acb[0] && !acb[2]) ? LMP_MT_DEV : LMP_MT_SO;
    if (!acb[2])
      return acb[0] ? LMP_MT_WBWA : LMP_MT_ONC;
    return acb[0] ? LMP_MT_WBNWA : LMP_MT_WTNWA;
  endfunction : exp_mt

  function automatic logic [7:0] exp_lanes(input logic [2:0] sz, input logic [2:0] ofs,
    input logic [7:0] st, input logic un);
    int n;
    n = (sz >= 3'h3) ? 8 : (1 << sz);
    if (st == 8'hFF && !un)
      return 8'(((16'h1 << n) - 16'h1) << ofs);
    return st;
  endfunction : exp_lanes

  // lookup hit l2rd fill master buf nomerge dl2 ddirty dmaster dalloc dfetch
  function automatic logic [11:0] exp_bits(input logic w, input lmp_memtype_e mt,
    input logic shd, input logic h, input logic wa, input logic [7:0] ln);
    logic [11:0] r;
    r = 12'h000;
    if (mt == LMP_MT_SO || mt == LMP_MT_DEV || mt == LMP_MT_ONC)
    begin
      r[7] = 1'b1;
      r[5] = w && mt == LMP_MT_DEV;
    end
    else if (shd)
    begin
      r[7] = !w;
      r[6] = w;
      r[2] = w;
    end
    else
    begin
      r[11] = 1'b1;
      r[10] = h;
      r[9] = !w && h;
      r[8] = !w && !h;
      r[6] = w;
      if (w && h)
      begin
        r[4] = 1'b1;
        r[2] = mt == LMP_MT_WTNWA;
        r[3] = mt != LMP_MT_WTNWA;
      end
      else if (w && (mt == LMP_MT_WBWA || wa))
      begin
        r[1] = 1'b1;
        r[0] = ln != 8'hFF;
      end
      else
        r[2] = w;
    end
    return r;
  endfunction : exp_bits

  // ----------------------------------------
  // compare, step and close
  // ----------------------------------------
  task automatic check_val(input logic [63:0] g, input logic [63:0] e);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected at %0t got %0h exp %0h", $time, g, e);
    end
  endtask : check_val

  task automatic step(input logic v, input logic w, input logic [2:0] acb, input logic s,
    input logic h, input logic wa, input logic so, input logic [2:0] sz,
    input logic [2:0] ofs, input logic [7:0] st, input logic un);
    @(negedge clk);
    if (e_v)
    begin
      `CHK(dec_valid, 1'b1);
      `CHK(dec_write, e_w);
      `CHK(dec_bits, e_bits);
      `CHK(dec_memtype, e_mt);
      `CHK(dec_shared, e_sh);
      `CHK(dec_lanes, e_lanes);
      `CHK(dec_unaligned, e_un);
    end
    else
      `CHK({dec_valid, dec_bits}, 13'h0000);
    wa_ov = wa;
    sh_ov = so;
    e_v = v;
    e_w = w;
    e_mt = exp_mt(acb);
    e_sh = (e_mt == LMP_MT_SO || e_mt == LMP_MT_DEV) ? 1'b1 : s && !so;
    e_lanes = exp_lanes(sz, ofs, st, un);
    e_bits = exp_bits(w, e_mt, e_sh, h, wa, e_lanes);
    e_un = un;
    u_lmp_core_model.put(v, w, acb, s, h, sz, {29'($random(seed)), ofs}, st, un);
  endtask : step

  task automatic do_reset;
    rst_n = 1'b0;
    repeat (5) @(negedge clk);
    `CHK({dec_valid, dec_memtype, dec_bits}, 16'h0000);
    rst_n = 1'b1;
    e_v = 1'b0;
  endtask : do_reset

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      summarize();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 36;
    wa_ov = 1'b0;
    sh_ov = 1'b0;
    do_reset();
    step(1, 0, 3'h3, 0, 0, 0, 0, 3'h3, 3'h0, 8'hFF, 0);
    step(1, 0, 3'h3, 0, 1, 0, 0, 3'h2, 3'h4, 8'hF0, 0);
    step(1, 1, 3'h3, 0, 0, 0, 0, 3'h2, 3'h0, 8'h0F, 0);
    step(1, 1, 3'h3, 0, 0, 0, 0, 3'h3, 3'h0, 8'hFF, 0);
    step(1, 1, 3'h7, 0, 0, 1, 0, 3'h1, 3'h2, 8'h0C, 0);
    step(1, 1, 3'h7, 1, 0, 1, 0, 3'h1, 3'h2, 8'h0C, 0);
    step(1, 1, 3'h3, 1, 1, 0, 1, 3'h0, 3'h5, 8'h20, 0);
    step(1, 0, 3'h5, 0, 1, 0, 1, 3'h0, 3'h1, 8'h02, 0);
    step(1, 1, 3'h1, 0, 1, 0, 1, 3'h2, 3'h4, 8'hF0, 0);
    step(1, 1, 3'h6, 0, 1, 0, 0, 3'h2, 3'h4, 8'h60, 1);
    step(1, 0, 3'h2, 1, 1, 0, 0, 3'h1, 3'h2, 8'hFF, 0);
    step(0, 0, 3'h0, 0, 0, 0, 0, 3'h0, 3'h0, 8'h00, 0);
    do_reset();
    $display("test corner done");
    repeat (600)
    begin
      sz = 3'($random(seed));
      ofs = 3'($random(seed)) & (3'h7 << (sz > 3'h3 ? 3'h3 : sz));
      leg = 1'($random(seed));
      st = leg ? 8'hFF : (exp_lanes(sz, ofs, 8'hFF, 1'b0) & 8'($random(seed)))
        | (8'h01 << ofs);
      step(3'($random(seed)) != 3'h0, 1'($random(seed)), 3'($random(seed)),
        1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 1'($random(seed)),
        sz, ofs, st, leg ? 1'b0 : 1'($random(seed)));
    end
    step(0, 0, 3'h0, 0, 0, 0, 0, 3'h0, 3'h0, 8'h00, 0);
    $display("test random done");
    summarize();
  end
endmodule : l2_memtype_access_policy_tb
